//--- core/bdcts_pkg.sv
/*
 Constants for the channel training status block.
 Assumes a 16-bit configuration register port with byte offsets.
*/
package bdcts_pkg;
    localparam int NUM_CHAN = 2;
    localparam int NUM_LANES = 14;
    localparam int IDLE_LANES = 3;
    localparam int CFG_W = 4;
    // Register offsets
    localparam logic [7:0] OFS_CHCFG_A = 8'h48;
    localparam logic [7:0] OFS_CHCFG_B = 8'h4a;
    localparam logic [7:0] OFS_STS_A = 8'h58;
    localparam logic [7:0] OFS_STS_B = 8'h5a;
    localparam logic [7:0] OFS_PRES_A = 8'h64;
    localparam logic [7:0] OFS_PRES_B = 8'h66;
    // Field positions
    localparam int FS_BIT = 8;
    localparam int NB_LSB = 4;
    localparam int SB_LSB = 0;
    // Reset values and masks
    localparam logic [15:0] CHCFG_RST = 16'h00ff;
    localparam logic [15:0] CHCFG_MASK = 16'h01ff;
    localparam logic [15:0] STS_RST = 16'h0000;
    localparam logic [15:0] PRES_RST = 16'h0000;
    localparam logic [3:0] LANE_CFG_DEF = 4'hf;
    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
    // Initialization pattern codes
    localparam logic [2:0] PAT_TS0 = 3'h0;
    localparam logic [2:0] PAT_TS1 = 3'h1;
    localparam logic [2:0] PAT_TS3 = 3'h3;
endpackage : bdcts_pkg

//--- core/bdcts_lane_detect.sv
/*
 Per-channel northbound lane pattern detection status.
 Assumes the receiver flags each lane match and the end of each pattern instance.
*/
`timescale 1ns/10ps
module bdcts_lane_detect (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Channel command state
    input wire logic in_init_in,
    input wire logic reset_done_in,
    input wire logic enable_in,
    input wire logic [2:0] pattern_in,
    input wire logic [3:0] buffer_identifier_in,
    input wire logic map_sel_exp_in,
    input wire logic [23:0] test_param_exp_in,
    // Receiver observations
    input wire logic rx_pattern_end_in,
    input wire logic [13:0] rx_lane_match_in,
    input wire logic [3:0] rx_buffer_id_in,
    input wire logic rx_map_sel_in,
    input wire logic [23:0] rx_test_param_in,
    input wire logic rx_stress_ok_in,
    // Status
    output logic [13:0] lane_pattern_seen_out
);
    logic [13:0] seen;
    logic prev_en;
    logic [2:0] prev_pat;
    logic [13:0] next_seen;
    logic cmd_changed;
    logic id_ok;
    logic ts1_ok;
    logic [13:0] cand;

    always_comb
    begin
        cmd_changed = (enable_in != prev_en) || (pattern_in != prev_pat);
        id_ok = rx_buffer_id_in == buffer_identifier_in;
        ts1_ok = (pattern_in != bdcts_pkg::PAT_TS1) ||
                 ((rx_map_sel_in == map_sel_exp_in) &&
                  (rx_test_param_in == test_param_exp_in) && rx_stress_ok_in);
        if (!enable_in)
        begin
            // Idle: only the low lanes, and only after channel reset
            cand = reset_done_in ? {11'h000, rx_lane_match_in[2:0]} : 14'h0000;
        end
        else
        begin
            cand = (id_ok && ts1_ok) ? rx_lane_match_in : 14'h0000;
        end
        next_seen = seen;
        // Status outside init states is held, not refreshed
        if (in_init_in && (rx_pattern_end_in || cmd_changed))
        begin
            next_seen = cand;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            seen <= bdcts_pkg::STS_RST[13:0];
            prev_en <= 1'b0;
            prev_pat <= bdcts_pkg::PAT_TS0;
        end
        else
        begin
            seen <= next_seen;
            prev_en <= enable_in;
            prev_pat <= pattern_in;
        end
    end

    assign lane_pattern_seen_out = seen;
endmodule : bdcts_lane_detect

//--- core/bdcts_status.sv
/*
 Training status, lane configuration and slot-present gating for two channels.
 Assumes a config port of single-cycle read and write strobes and a link layer
 that reports pattern ends, fast-reset TS1 outcomes and buffer access requests.
*/
`timescale 1ns/10ps
module bdcts_status (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Configuration register port
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [15:0] cfg_wdata_in,
    output logic [15:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    // Per-channel command state
    input wire logic [1:0] in_init_in,
    input wire logic [1:0] reset_done_in,
    input wire logic [1:0] cmd_enable_in,
    input wire logic [1:0][2:0] init_pattern_select_in,
    input wire logic [1:0][3:0] buffer_identifier_in,
    input wire logic [1:0] map_sel_exp_in,
    input wire logic [1:0][23:0] test_param_exp_in,
    // Per-channel receiver observations
    input wire logic [1:0] rx_pattern_end_in,
    input wire logic [1:0][13:0] rx_lane_match_in,
    input wire logic [1:0][3:0] rx_buffer_id_in,
    input wire logic [1:0] rx_map_sel_in,
    input wire logic [1:0][23:0] rx_test_param_in,
    input wire logic [1:0] rx_stress_ok_in,
    // Fast reset and training progress
    input wire logic [1:0] bitlock_timeout_in,
    input wire logic [1:0] fr_ts1_done_in,
    input wire logic [1:0][3:0] ts1_nb_result_in,
    input wire logic [1:0][3:0] ts1_sb_result_in,
    // Channel drive
    output logic [1:0] tx_electrical_idle_out,
    output logic [1:0][2:0] tx_pattern_out,
    output logic [1:0][3:0] tx_buffer_identifier_out,
    output logic [1:0] tx_cfg_valid_out,
    output logic [1:0][3:0] tx_nb_cfg_out,
    output logic [1:0][3:0] tx_sb_cfg_out,
    output logic [1:0][13:0] retrain_skip_out,
    output logic [1:0] ts0_advance_out,
    // Buffer configuration requests
    input wire logic amb_req_in,
    input wire logic amb_req_via_window_in,
    input wire logic amb_req_chan_in,
    input wire logic [3:0] amb_req_slot_in,
    input wire logic amb_req_write_in,
    output logic amb_fwd_out,
    output logic amb_fwd_via_window_out,
    output logic amb_fwd_chan_out,
    output logic [3:0] amb_fwd_slot_out,
    output logic amb_fwd_write_out,
    output logic amb_local_done_out,
    output logic [31:0] amb_local_rdata_out
);
    logic [1:0][15:0] chcfg;
    logic [1:0][15:0] slot_mask;
    logic [1:0][13:0] failed;
    logic [1:0][13:0] seen;
    logic [1:0][15:0] next_chcfg;
    logic [1:0][15:0] next_slot_mask;
    logic [1:0][13:0] next_failed;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic present;

    // Slot select n is gated by mask bit n
    function automatic logic slot_ok(input logic [15:0] mask, input logic [3:0] sel);
        slot_ok = mask[sel];
    endfunction : slot_ok

    function automatic logic [15:0] sts_word(input logic [13:0] lanes);
        sts_word = {2'b00, lanes};
    endfunction : sts_word

    genvar gc;
    generate
        for (gc = 0; gc < bdcts_pkg::NUM_CHAN; gc++)
        begin : g_chan
            bdcts_lane_detect u_det (
                .clk_sys_in(clk_sys_in),
                .reset_in(reset_in),
                .in_init_in(in_init_in[gc]),
                .reset_done_in(reset_done_in[gc]),
                .enable_in(cmd_enable_in[gc]),
                .pattern_in(init_pattern_select_in[gc]),
                .buffer_identifier_in(buffer_identifier_in[gc]),
                .map_sel_exp_in(map_sel_exp_in[gc]),
                .test_param_exp_in(test_param_exp_in[gc]),
                .rx_pattern_end_in(rx_pattern_end_in[gc]),
                .rx_lane_match_in(rx_lane_match_in[gc]),
                .rx_buffer_id_in(rx_buffer_id_in[gc]),
                .rx_map_sel_in(rx_map_sel_in[gc]),
                .rx_test_param_in(rx_test_param_in[gc]),
                .rx_stress_ok_in(rx_stress_ok_in[gc]),
                .lane_pattern_seen_out(seen[gc])
            );
        end
    endgenerate

    // Register writes and fast-reset updates
    always_comb
    begin
        next_chcfg = chcfg;
        next_slot_mask = slot_mask;
        next_failed = failed;
        if (cfg_wr_in)
        begin
            case (cfg_addr_in)
                bdcts_pkg::OFS_CHCFG_A: next_chcfg[0] = cfg_wdata_in & bdcts_pkg::CHCFG_MASK;
                bdcts_pkg::OFS_CHCFG_B: next_chcfg[1] = cfg_wdata_in & bdcts_pkg::CHCFG_MASK;
                bdcts_pkg::OFS_PRES_A: next_slot_mask[0] = cfg_wdata_in;
                bdcts_pkg::OFS_PRES_B: next_slot_mask[1] = cfg_wdata_in;
                default: ;
            endcase
        end
        for (int c = 0; c < bdcts_pkg::NUM_CHAN; c++)
        begin
            // Clearing sticky failover forgets the failed lanes
            if (!next_chcfg[c][bdcts_pkg::FS_BIT])
            begin
                next_failed[c] = 14'h0000;
            end
            // Lanes still dark at bit-lock timeout are remembered as failed
            if (bitlock_timeout_in[c])
            begin
                next_failed[c] = next_failed[c] | ~seen[c];
            end
            // Hardware update wins over a same-cycle software write
            if (fr_ts1_done_in[c])
            begin
                if (!chcfg[c][bdcts_pkg::FS_BIT] ||
                    chcfg[c][bdcts_pkg::NB_LSB +: 4] == bdcts_pkg::LANE_CFG_DEF)
                begin
                    next_chcfg[c][bdcts_pkg::NB_LSB +: 4] = ts1_nb_result_in[c];
                end
                if (!chcfg[c][bdcts_pkg::FS_BIT] ||
                    chcfg[c][bdcts_pkg::SB_LSB +: 4] == bdcts_pkg::LANE_CFG_DEF)
                begin
                    next_chcfg[c][bdcts_pkg::SB_LSB +: 4] = ts1_sb_result_in[c];
                end
            end
        end
    end

    // Register reads; unmapped offsets read zero
    always_comb
    begin
        next_rvalid = cfg_rd_in;
        case (cfg_addr_in)
            bdcts_pkg::OFS_CHCFG_A: next_rdata = chcfg[0];
            bdcts_pkg::OFS_CHCFG_B: next_rdata = chcfg[1];
            bdcts_pkg::OFS_STS_A: next_rdata = sts_word(seen[0]);
            bdcts_pkg::OFS_STS_B: next_rdata = sts_word(seen[1]);
            bdcts_pkg::OFS_PRES_A: next_rdata = slot_mask[0];
            bdcts_pkg::OFS_PRES_B: next_rdata = slot_mask[1];
            default: next_rdata = 16'h0000;
        endcase
        if (!cfg_rd_in)
        begin
            next_rdata = cfg_rdata_out;
        end
    end

    // Window and select requests share the same gate
    assign present = slot_ok(slot_mask[amb_req_chan_in], amb_req_slot_in);

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            chcfg <= {bdcts_pkg::CHCFG_RST, bdcts_pkg::CHCFG_RST};
            slot_mask <= {bdcts_pkg::PRES_RST, bdcts_pkg::PRES_RST};
            failed <= '0;
            cfg_rdata_out <= 16'h0000;
            cfg_rvalid_out <= 1'b0;
            tx_electrical_idle_out <= 2'b11;
            tx_pattern_out <= '0;
            tx_buffer_identifier_out <= '0;
            tx_cfg_valid_out <= 2'b00;
            tx_nb_cfg_out <= {bdcts_pkg::LANE_CFG_DEF, bdcts_pkg::LANE_CFG_DEF};
            tx_sb_cfg_out <= {bdcts_pkg::LANE_CFG_DEF, bdcts_pkg::LANE_CFG_DEF};
            retrain_skip_out <= '0;
            ts0_advance_out <= 2'b00;
            amb_fwd_out <= 1'b0;
            amb_fwd_via_window_out <= 1'b0;
            amb_fwd_chan_out <= 1'b0;
            amb_fwd_slot_out <= 4'h0;
            amb_fwd_write_out <= 1'b0;
            amb_local_done_out <= 1'b0;
            amb_local_rdata_out <= 32'h0000_0000;
        end
        else
        begin
            chcfg <= next_chcfg;
            slot_mask <= next_slot_mask;
            failed <= next_failed;
            cfg_rdata_out <= next_rdata;
            cfg_rvalid_out <= next_rvalid;
            for (int c = 0; c < bdcts_pkg::NUM_CHAN; c++)
            begin
                tx_electrical_idle_out[c] <= !cmd_enable_in[c];
                tx_pattern_out[c] <= init_pattern_select_in[c];
                tx_buffer_identifier_out[c] <= buffer_identifier_in[c];
                tx_cfg_valid_out[c] <= cmd_enable_in[c] &&
                    init_pattern_select_in[c] == bdcts_pkg::PAT_TS3;
                tx_nb_cfg_out[c] <= chcfg[c][bdcts_pkg::NB_LSB +: 4];
                tx_sb_cfg_out[c] <= chcfg[c][bdcts_pkg::SB_LSB +: 4];
                retrain_skip_out[c] <= chcfg[c][bdcts_pkg::FS_BIT] ? failed[c] : 14'h0000;
                // Failed lanes count as trained only under sticky failover
                ts0_advance_out[c] <= bitlock_timeout_in[c] ||
                    &(seen[c] | (chcfg[c][bdcts_pkg::FS_BIT] ? failed[c] : 14'h0000));
            end
            amb_fwd_out <= amb_req_in && present;
            amb_fwd_via_window_out <= amb_req_via_window_in;
            amb_fwd_chan_out <= amb_req_chan_in;
            amb_fwd_slot_out <= amb_req_slot_in;
            amb_fwd_write_out <= amb_req_write_in;
            amb_local_done_out <= amb_req_in && !present;
            amb_local_rdata_out <= bdcts_pkg::ALL_ONES;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    AST_SLOT_FWD: assert property (
        amb_req_in && slot_mask[amb_req_chan_in][amb_req_slot_in]
        |=> amb_fwd_out && !amb_local_done_out && amb_fwd_slot_out == $past(amb_req_slot_in))
        else $error("Present slot access not forwarded");

    AST_SLOT_LOCAL: assert property (
        amb_req_in && !slot_mask[amb_req_chan_in][amb_req_slot_in]
        |=> !amb_fwd_out && amb_local_done_out && amb_local_rdata_out == 32'hffff_ffff)
        else $error("Empty slot access not completed locally");

    AST_IDLE_LOW_LANES: assert property (
        in_init_in[0] && !cmd_enable_in[0] && rx_pattern_end_in[0]
        |=> seen[0][13:3] == 11'h000)
        else $error("Upper lanes reported during idle");

    AST_ID_MISMATCH: assert property (
        in_init_in[0] && cmd_enable_in[0] && rx_pattern_end_in[0]
        && rx_buffer_id_in[0] != buffer_identifier_in[0]
        |=> seen[0] == 14'h0000)
        else $error("Lanes seen with wrong identifier");

    AST_TS3_CFG: assert property (
        cmd_enable_in[0] && init_pattern_select_in[0] == 3'h3 |=> tx_cfg_valid_out[0])
        else $error("Lane configs not sent in TS3");

    AST_IDLE_DRIVE: assert property (
        ##1 tx_electrical_idle_out[1] == !$past(cmd_enable_in[1]))
        else $error("Channel drive does not follow enable");

    AST_FS0_UPDATE: assert property (
        fr_ts1_done_in[0] && !chcfg[0][8]
        |=> chcfg[0][7:4] == $past(ts1_nb_result_in[0]) ##1 tx_nb_cfg_out[0] == $past(chcfg[0][7:4]))
        else $error("Config not updated in fast reset");

    AST_FS1_HOLD: assert property (
        fr_ts1_done_in[1] && chcfg[1][8] && chcfg[1][3:0] != 4'hf
        && !(cfg_wr_in && cfg_addr_in == 8'h4a)
        |=> $stable(chcfg[1][3:0]))
        else $error("Non-default config overwritten under sticky failover");

    AST_STS_READ: assert property (
        cfg_rd_in && cfg_addr_in == 8'h58 |=> cfg_rvalid_out && cfg_rdata_out == {2'b00, $past(seen[0])})
        else $error("Status read wrong");

    AST_TS0_TIMEOUT: assert property (
        bitlock_timeout_in[0] |=> ts0_advance_out[0])
        else $error("Training not released at bit-lock timeout");

    COV_FWD: cover property (amb_req_in ##1 amb_fwd_out);
    COV_LOCAL: cover property (amb_req_in && !amb_req_write_in ##1 amb_local_done_out);
    COV_FR_UPDATE: cover property (fr_ts1_done_in[0] ##1 chcfg[0][7:4] != 4'hf);
    COV_TS0_DONE: cover property (in_init_in[0] ##[1:20] ts0_advance_out[0]);
endmodule : bdcts_status

//--- dv/bdcts_amb_model.sv
/*
 Behavioural chain of memory buffers as seen by one channel's receiver.
 Assumes every task is entered at a falling clock edge and returns on one.
*/
`timescale 1ns/10ps
module bdcts_amb_model (
    // Clock
    input wire logic clk_sys_in,
    // Received training content
    output logic rx_pattern_end_out,
    output logic [13:0] rx_lane_match_out,
    output logic [3:0] rx_buffer_id_out,
    output logic rx_map_sel_out,
    output logic [23:0] rx_test_param_out,
    output logic rx_stress_ok_out,
    // Fast reset outcome
    output logic fr_ts1_done_out,
    output logic [3:0] ts1_nb_result_out,
    output logic [3:0] ts1_sb_result_out
);
    initial
    begin
        {rx_pattern_end_out, rx_lane_match_out, rx_buffer_id_out, rx_map_sel_out} = '0;
        {rx_test_param_out, rx_stress_ok_out, fr_ts1_done_out} = '0;
        {ts1_nb_result_out, ts1_sb_result_out} = '0;
    end

    // Content except the stress flag is inverted once released so a stale copy never passes for a fresh one
    task automatic frame(input logic [13:0] lanes, input logic [3:0] id, input logic map,
        input logic [23:0] prm, input logic stress, input logic with_end);
        rx_lane_match_out = lanes;
        rx_buffer_id_out = id;
        rx_map_sel_out = map;
        rx_test_param_out = prm;
        rx_stress_ok_out = stress;
        rx_pattern_end_out = with_end;
        @(negedge clk_sys_in);
        rx_pattern_end_out = 1'b0;
        rx_lane_match_out = ~lanes;
        rx_buffer_id_out = ~id;
        rx_test_param_out = ~prm;
        rx_map_sel_out = ~map;
        @(negedge clk_sys_in);
    endtask : frame

    task automatic fast_reset(input logic [3:0] nb, input logic [3:0] sb);
        fr_ts1_done_out = 1'b1;
        ts1_nb_result_out = nb;
        ts1_sb_result_out = sb;
        @(negedge clk_sys_in);
        fr_ts1_done_out = 1'b0;
        ts1_nb_result_out = ~nb;
        ts1_sb_result_out = ~sb;
        @(negedge clk_sys_in);
    endtask : fast_reset
endmodule : bdcts_amb_model

//--- dv/bdcts_status_test.sv
/*
 Self-checking bench for the channel training status block.
 Assumes inputs change on falling edges and a model per channel feeds the receiver side.
*/
`timescale 1ns/10ps
module bdcts_status_test;
    logic clk_sys_in = 1'b0;
    logic reset_in, cfg_wr_in, cfg_rd_in, amb_req_in, amb_req_via_window_in, amb_req_chan_in, amb_req_write_in;
    logic [7:0] cfg_addr_in;
    logic [15:0] cfg_wdata_in;
    logic [1:0] in_init_in, reset_done_in, cmd_enable_in, map_sel_exp_in, bitlock_timeout_in;
    logic [1:0][2:0] init_pattern_select_in;
    logic [1:0][3:0] buffer_identifier_in;
    logic [1:0][23:0] test_param_exp_in;
    logic [3:0] amb_req_slot_in;
    wire [1:0] rx_pattern_end_in, rx_map_sel_in, rx_stress_ok_in, fr_ts1_done_in;
    wire [1:0][13:0] rx_lane_match_in, retrain_skip_out;
    wire [1:0][3:0] rx_buffer_id_in, ts1_nb_result_in, ts1_sb_result_in;
    wire [1:0][23:0] rx_test_param_in;
    wire [15:0] cfg_rdata_out;
    wire cfg_rvalid_out, amb_fwd_out, amb_fwd_via_window_out, amb_fwd_chan_out, amb_fwd_write_out, amb_local_done_out;
    wire [1:0] tx_electrical_idle_out, tx_cfg_valid_out, ts0_advance_out;
    wire [1:0][2:0] tx_pattern_out;
    wire [1:0][3:0] tx_buffer_identifier_out, tx_nb_cfg_out, tx_sb_cfg_out;
    wire [3:0] amb_fwd_slot_out;
    wire [31:0] amb_local_rdata_out;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    bdcts_status dut (.clk_sys_in, .reset_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out,
        .cfg_rvalid_out, .in_init_in, .reset_done_in, .cmd_enable_in, .init_pattern_select_in, .buffer_identifier_in,
        .map_sel_exp_in, .test_param_exp_in, .rx_pattern_end_in, .rx_lane_match_in, .rx_buffer_id_in, .rx_map_sel_in,
        .rx_test_param_in, .rx_stress_ok_in, .bitlock_timeout_in, .fr_ts1_done_in, .ts1_nb_result_in,
        .ts1_sb_result_in, .tx_electrical_idle_out, .tx_pattern_out, .tx_buffer_identifier_out, .tx_cfg_valid_out,
        .tx_nb_cfg_out, .tx_sb_cfg_out, .retrain_skip_out, .ts0_advance_out, .amb_req_in, .amb_req_via_window_in,
        .amb_req_chan_in, .amb_req_slot_in, .amb_req_write_in, .amb_fwd_out, .amb_fwd_via_window_out,
        .amb_fwd_chan_out, .amb_fwd_slot_out, .amb_fwd_write_out, .amb_local_done_out, .amb_local_rdata_out);

    bdcts_amb_model mdl_a (.clk_sys_in, .rx_pattern_end_out(rx_pattern_end_in[0]),
        .rx_lane_match_out(rx_lane_match_in[0]), .rx_buffer_id_out(rx_buffer_id_in[0]),
        .rx_map_sel_out(rx_map_sel_in[0]), .rx_test_param_out(rx_test_param_in[0]),
        .rx_stress_ok_out(rx_stress_ok_in[0]), .fr_ts1_done_out(fr_ts1_done_in[0]),
        .ts1_nb_result_out(ts1_nb_result_in[0]), .ts1_sb_result_out(ts1_sb_result_in[0]));
    bdcts_amb_model mdl_b (.clk_sys_in, .rx_pattern_end_out(rx_pattern_end_in[1]),
        .rx_lane_match_out(rx_lane_match_in[1]), .rx_buffer_id_out(rx_buffer_id_in[1]),
        .rx_map_sel_out(rx_map_sel_in[1]), .rx_test_param_out(rx_test_param_in[1]),
        .rx_stress_ok_out(rx_stress_ok_in[1]), .fr_ts1_done_out(fr_ts1_done_in[1]),
        .ts1_nb_result_out(ts1_nb_result_in[1]), .ts1_sb_result_out(ts1_sb_result_in[1]));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cfg_addr_in = a;
        cfg_wdata_in = d;
        cfg_wr_in = 1'b1;
        @(negedge clk_sys_in);
        cfg_wr_in = 1'b0;
        @(negedge clk_sys_in);
    endtask : wr

    // Valid stands one cycle only, so it is sampled at the first falling edge
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
        cfg_addr_in = a;
        cfg_rd_in = 1'b1;
        @(negedge clk_sys_in);
        cfg_rd_in = 1'b0;
        chk({cfg_rvalid_out, cfg_rdata_out}, {1'b1, exp}, what);
        @(negedge clk_sys_in);
    endtask : rd_chk

    task automatic t_reset;
        rd_chk(8'h48, 16'h00ff, "cfg a reset");
        rd_chk(8'h4a, 16'h00ff, "cfg b reset");
        rd_chk(8'h58, 16'h0000, "status a reset");
        rd_chk(8'h66, 16'h0000, "mask b reset");
        chk({tx_electrical_idle_out, tx_nb_cfg_out, tx_sb_cfg_out}, {2'b11, 16'hffff}, "drive reset");
    endtask : t_reset

    task automatic t_regs;
        wr(8'h48, 16'hfe5a);
        rd_chk(8'h48, 16'h005a, "cfg reserved bits");
        chk({tx_nb_cfg_out[0], tx_sb_cfg_out[0]}, 8'h5a, "sent configs");
        wr(8'h58, 16'hffff);
        rd_chk(8'h58, 16'h0000, "status read only");
        wr(8'h70, 16'h1234);
        rd_chk(8'h70, 16'h0000, "unmapped");
    endtask : t_regs

    task automatic t_drive;
        cmd_enable_in = 2'b01;
        init_pattern_select_in[0] = bdcts_pkg::PAT_TS3;
        buffer_identifier_in[0] = 4'h9;
        repeat (2) @(negedge clk_sys_in);
        chk({tx_electrical_idle_out, tx_cfg_valid_out}, 4'b1001, "enable ts3");
        chk({tx_pattern_out[0], tx_buffer_identifier_out[0]}, 7'h39, "pattern and id");
        cmd_enable_in = 2'b00;
        repeat (2) @(negedge clk_sys_in);
        chk({tx_electrical_idle_out, tx_cfg_valid_out}, 4'b1100, "idle");
    endtask : t_drive

    task automatic t_lanes;
        in_init_in = 2'b11;
        cmd_enable_in = 2'b11;
        init_pattern_select_in = '0;
        buffer_identifier_in[1] = 4'h3;
        mdl_a.frame(14'h2a5c, 4'h9, 1'b0, 24'h0, 1'b1, 1'b1);
        rd_chk(8'h58, 16'h2a5c, "ts0 detect");
        mdl_a.frame(14'h3fff, 4'h6, 1'b0, 24'h0, 1'b1, 1'b1);
        rd_chk(8'h58, 16'h0000, "wrong id");
        init_pattern_select_in[0] = bdcts_pkg::PAT_TS1;
        map_sel_exp_in = 2'b01;
        test_param_exp_in[0] = 24'h5a0f3c;
        mdl_a.frame(14'h1234, 4'h9, 1'b1, 24'h5a0f3c, 1'b1, 1'b1);
        rd_chk(8'h58, 16'h1234, "ts1 detect");
        mdl_a.frame(14'h1234, 4'h9, 1'b1, 24'h5a0f3d, 1'b1, 1'b1);
        rd_chk(8'h58, 16'h0000, "ts1 bad params");
        mdl_a.frame(14'h1234, 4'h9, 1'b0, 24'h5a0f3c, 1'b1, 1'b1);
        rd_chk(8'h58, 16'h0000, "ts1 bad mapping");
        mdl_a.frame(14'h1234, 4'h9, 1'b1, 24'h5a0f3c, 1'b0, 1'b1);
        rd_chk(8'h58, 16'h0000, "ts1 bad stress");
        // No pattern end here: the selection change alone must refresh
        init_pattern_select_in[0] = bdcts_pkg::PAT_TS0;
        mdl_a.frame(14'h0ff0, 4'h9, 1'b0, 24'h0, 1'b1, 1'b0);
        rd_chk(8'h58, 16'h0ff0, "change refresh");
        in_init_in = 2'b10;
        mdl_a.frame(14'h0001, 4'h9, 1'b0, 24'h0, 1'b1, 1'b1);
        rd_chk(8'h58, 16'h0ff0, "held outside init");
        in_init_in = 2'b11;
        cmd_enable_in = 2'b10;
        reset_done_in = 2'b01;
        mdl_a.frame(14'h3fff, 4'h0, 1'b0, 24'h0, 1'b0, 1'b1);
        rd_chk(8'h58, 16'h0007, "idle low lanes");
        reset_done_in = 2'b00;
        mdl_a.frame(14'h3fff, 4'h0, 1'b0, 24'h0, 1'b0, 1'b1);
        rd_chk(8'h58, 16'h0000, "idle before reset done");
        mdl_b.frame(14'h0421, 4'h3, 1'b0, 24'h0, 1'b1, 1'b1);
        rd_chk(8'h5a, 16'h0421, "channel b detect");
    endtask : t_lanes

    task automatic t_fast;
        mdl_a.fast_reset(4'h2, 4'h3);
        rd_chk(8'h48, 16'h0023, "fast reset update");
        chk({tx_nb_cfg_out[0], tx_sb_cfg_out[0], retrain_skip_out[0]}, {8'h23, 14'h0}, "sent after update");
        wr(8'h48, 16'h01f3);
        mdl_a.fast_reset(4'h5, 4'h6);
        rd_chk(8'h48, 16'h0153, "sticky default only");
        mdl_a.fast_reset(4'h7, 4'h8);
        rd_chk(8'h48, 16'h0153, "sticky keeps");
        // Status A is all dark here, so every lane fails at the timeout
        bitlock_timeout_in = 2'b01;
        @(negedge clk_sys_in);
        bitlock_timeout_in = 2'b00;
        @(negedge clk_sys_in);
        chk({retrain_skip_out[0], ts0_advance_out[0]}, {14'h3fff, 1'b1}, "failed lanes skipped");
        wr(8'h48, 16'h0053);
        chk({retrain_skip_out[0], ts0_advance_out[0]}, 15'h0000, "sticky cleared");
        wr(8'h4a, 16'h01f3);
        mdl_b.fast_reset(4'h7, 4'h8);
        rd_chk(8'h4a, 16'h0173, "channel b sticky");
    endtask : t_fast

    // Request stays raised between calls so back-to-back requests are taken
    task automatic req(input logic ch, input logic [3:0] slot, input logic win, input logic w, input logic fwd);
        {amb_req_in, amb_req_chan_in, amb_req_slot_in, amb_req_via_window_in, amb_req_write_in} = {1'b1, ch, slot, win, w};
        @(negedge clk_sys_in);
        if (fwd)
            chk({amb_fwd_out, amb_local_done_out, amb_fwd_chan_out, amb_fwd_slot_out, amb_fwd_via_window_out,
                amb_fwd_write_out}, {2'b10, ch, slot, win, w}, "forwarded");
        else
            chk({amb_fwd_out, amb_local_done_out, amb_local_rdata_out}, {2'b01, 32'hffffffff}, "local");
    endtask : req

    task automatic t_slots;
        // Mask is programmed once presence discovery is over
        wr(8'h64, 16'h8001);
        wr(8'h66, 16'h0020);
        rd_chk(8'h64, 16'h8001, "mask a");
        req(1'b0, 4'hf, 1'b1, 1'b0, 1'b1);
        req(1'b0, 4'h0, 1'b0, 1'b1, 1'b1);
        req(1'b0, 4'h5, 1'b1, 1'b0, 1'b0);
        req(1'b1, 4'h5, 1'b0, 1'b1, 1'b1);
        req(1'b1, 4'hf, 1'b1, 1'b1, 1'b0);
        req(1'b0, 4'he, 1'b0, 1'b0, 1'b0);
        amb_req_in = 1'b0;
        @(negedge clk_sys_in);
        chk({amb_fwd_out, amb_local_done_out}, 2'b00, "one cycle answer");
    endtask : t_slots

    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Whole run is about 110 cycles; the ceiling leaves wide margin
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles >= 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial
    begin
        {reset_in, cfg_wr_in, cfg_rd_in, cfg_addr_in, cfg_wdata_in} = {1'b1, 26'h0};
        {in_init_in, reset_done_in, cmd_enable_in, map_sel_exp_in, bitlock_timeout_in} = '0;
        {init_pattern_select_in, buffer_identifier_in, test_param_exp_in} = '0;
        {amb_req_in, amb_req_via_window_in, amb_req_chan_in, amb_req_slot_in, amb_req_write_in} = '0;
        repeat (4) @(negedge clk_sys_in);
        reset_in = 1'b0;
        t_reset();
        t_regs();
        t_drive();
        t_lanes();
        t_fast();
        t_slots();
        tally_and_finish();
    end
endmodule : bdcts_status_test
